// *** logic/ipc_controller.sv ***
// Interrupt priority and source controller with AXI4-Lite register access.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`include "ipc_cfg.svh"
module ipc_controller #(
  parameter int STACK_DEPTH = `IPC_STACK_DEPTH
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] extIrqPin,
  input wire logic [3:0] portChangePin,
  input wire logic [7:0] timer0CountLow,
  input wire logic [7:0] timer0CountHigh,
  input wire logic [7:0] peripheralRequest,
  input wire logic [15:0] otherRequest,
  input wire logic sleepEnter,
  input wire logic interruptTaken,
  input wire logic fastReturn,
  input wire ipc_pkg::ipc_context_t coreContext,
  output ipc_pkg::ipc_request_t irqRequest,
  output logic wakeUp,
  output logic vectorEnable,
  output ipc_pkg::ipc_context_t fastStack,
  output logic [`IPC_PC_WIDTH-1:0] stackTop
);
  logic [7:0] prioA_reg;
  logic [7:0] prioB_reg;
  logic [7:0] prioC_reg;
  logic [7:0] ctrlMain_reg;
  logic [7:0] ctrlSecond_reg;
  logic [7:0] ctrlThird_reg;
  logic t16Mode_reg;
  logic sleeping_reg;
  logic [7:0] t0Low_reg;
  logic [7:0] t0High_reg;
  logic [3:0] extEdge;
  logic [3:0] portChange;
  logic [3:0] extEdgeSelect;
  logic [3:0] extFlag;
  logic [3:0] extEnable;
  logic [3:0] extPrio;
  logic t0Overflow;
  logic [7:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic awHeld_reg;
  logic wHeld_reg;
  logic doWrite;
  logic [31:0] readData;
  logic readHit;
  logic [23:0] highPend;
  logic [23:0] lowPend;
  logic anyEnabledPend;
  logic [$clog2(STACK_DEPTH+1)-1:0] stackPtr_reg;
  logic [`IPC_PC_WIDTH-1:0] stackMem [STACK_DEPTH];

  // Pin 0 owns the highest select bit, so the field runs downward from it.
  for (genvar p = 0; p < 4; p++)
  begin : g_edge_sel
    assign extEdgeSelect[p] = ctrlSecond_reg[`IPC_B_EDGE0 - p];
  end
  assign extFlag = {ctrlThird_reg[`IPC_B_P1IF +: 3], ctrlMain_reg[`IPC_B_P0IF]};
  assign extEnable = {ctrlThird_reg[`IPC_B_P1IE +: 3], ctrlMain_reg[`IPC_B_P0IE]};
  assign extPrio = {ctrlThird_reg[`IPC_B_P3IP], ctrlSecond_reg[`IPC_B_P2IP], ctrlThird_reg[`IPC_B_P1IP], 1'b1};

  ipc_edge_detect #(.WIDTH(4)) u_ext_edge (
    .clock(clock),
    .reset(reset),
    .pinAsync(extIrqPin),
    .risingSelect(extEdgeSelect),
    .validEdge(extEdge),
    .anyChange()
  );

  ipc_edge_detect #(.WIDTH(4)) u_port_change (
    .clock(clock),
    .reset(reset),
    .pinAsync(portChangePin),
    .risingSelect(4'h0),
    .validEdge(),
    .anyChange(portChange)
  );

  // Timer0 rollover seen as the count wrapping from its top value to zero.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      t0Low_reg <= '0;
      t0High_reg <= '0;
    end
    else
    begin
      t0Low_reg <= timer0CountLow;
      t0High_reg <= timer0CountHigh;
    end
  end
  assign t0Overflow = t16Mode_reg ?
    ({t0High_reg, t0Low_reg} == `IPC_T16_MAX && {timer0CountHigh, timer0CountLow} == 16'h0000) :
    (t0Low_reg == `IPC_T8_MAX && timer0CountLow == 8'h00);

  // AXI4-Lite write path: address and data taken in either order.
  assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      awHeld_reg <= 1'b0;
      wHeld_reg <= 1'b0;
      awAddr_reg <= '0;
      wData_reg <= '0;
      wStrb_reg <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IPC_RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHeld_reg && !s_axi_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHeld_reg && !s_axi_bvalid && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld_reg <= 1'b1;
        awAddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld_reg <= 1'b1;
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        awHeld_reg <= 1'b0;
        wHeld_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr_reg > `IPC_OFS_CORE || awAddr_reg[1:0] != 2'b00 || awAddr_reg == `IPC_OFS_FLAGS) ?
          `IPC_RESP_SLVERR : `IPC_RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Priority, second control and core mode registers; only byte lane 0 carries data.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      prioA_reg <= `IPC_RST_PRIO;
      prioB_reg <= `IPC_RST_PRIO & `IPC_PRIO_B_MASK;
      prioC_reg <= `IPC_RST_PRIO;
      ctrlSecond_reg <= `IPC_RST_CTRL_SECOND;
      t16Mode_reg <= 1'b0;
    end
    else if (doWrite && wStrb_reg[0])
    begin
      unique case (awAddr_reg)
        `IPC_OFS_PRIO_A: prioA_reg <= wData_reg[7:0];
        `IPC_OFS_PRIO_B: prioB_reg <= wData_reg[7:0] & `IPC_PRIO_B_MASK;
        `IPC_OFS_PRIO_C: prioC_reg <= wData_reg[7:0];
        `IPC_OFS_CTRL_SECOND: ctrlSecond_reg <= wData_reg[7:0];
        `IPC_OFS_CORE: t16Mode_reg <= wData_reg[`IPC_B_T16];
        default:
        begin
        end
      endcase
    end
  end

  // Control registers holding flags: hardware set wins over a software write in the same cycle.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      ctrlMain_reg <= '0;
      ctrlThird_reg <= `IPC_RST_CTRL_THIRD;
    end
    else
    begin
      if (doWrite && wStrb_reg[0] && awAddr_reg == `IPC_OFS_CTRL_MAIN)
        ctrlMain_reg <= wData_reg[7:0] | {5'b0_0000, t0Overflow, extEdge[0], |portChange};
      else
      begin
        ctrlMain_reg[`IPC_B_T0IF] <= ctrlMain_reg[`IPC_B_T0IF] | t0Overflow;
        ctrlMain_reg[`IPC_B_P0IF] <= ctrlMain_reg[`IPC_B_P0IF] | extEdge[0];
        ctrlMain_reg[`IPC_B_PORT_CHANGE_FLAG] <= ctrlMain_reg[`IPC_B_PORT_CHANGE_FLAG] | (|portChange);
      end
      if (doWrite && wStrb_reg[0] && awAddr_reg == `IPC_OFS_CTRL_THIRD)
        ctrlThird_reg <= wData_reg[7:0] | {5'b0_0000, extEdge[3:1]};
      else
        ctrlThird_reg[`IPC_B_P1IF +: 3] <= ctrlThird_reg[`IPC_B_P1IF +: 3] | extEdge[3:1];
    end
  end

  // Pending sources split by priority.
  always_comb
  begin
    highPend = '0;
    lowPend = '0;
    for (int i = 0; i < 4; i++)
    begin
      highPend[i] = extFlag[i] & extEnable[i] & extPrio[i];
      lowPend[i] = extFlag[i] & extEnable[i] & ~extPrio[i];
    end
    highPend[4] = ctrlMain_reg[`IPC_B_T0IF] & ctrlMain_reg[`IPC_B_T0IE] & ctrlSecond_reg[`IPC_B_T0IP];
    lowPend[4] = ctrlMain_reg[`IPC_B_T0IF] & ctrlMain_reg[`IPC_B_T0IE] & ~ctrlSecond_reg[`IPC_B_T0IP];
    highPend[5] = ctrlMain_reg[`IPC_B_PORT_CHANGE_FLAG] & ctrlMain_reg[`IPC_B_PORT_CHANGE_ENABLE] & ctrlSecond_reg[`IPC_B_PORT_CHANGE_PRIO];
    lowPend[5] = ctrlMain_reg[`IPC_B_PORT_CHANGE_FLAG] & ctrlMain_reg[`IPC_B_PORT_CHANGE_ENABLE] & ~ctrlSecond_reg[`IPC_B_PORT_CHANGE_PRIO];
    highPend[15:8] = peripheralRequest & prioA_reg;
    lowPend[15:8] = peripheralRequest & ~prioA_reg;
    highPend[23:16] = otherRequest[7:0] & prioB_reg;
    lowPend[23:16] = otherRequest[7:0] & ~prioB_reg & `IPC_PRIO_B_MASK;
    highPend[7:6] = {|(otherRequest[15:8] & prioC_reg), 1'b0};
    lowPend[7:6] = {|(otherRequest[15:8] & ~prioC_reg), 1'b0};
  end
  assign anyEnabledPend = |highPend | |lowPend;

  // Request, sleep and wake outputs; all registered.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      irqRequest <= '0;
      sleeping_reg <= 1'b0;
      wakeUp <= 1'b0;
      vectorEnable <= 1'b0;
    end
    else
    begin
      irqRequest.high <= ctrlMain_reg[`IPC_B_GIE] & (|highPend);
      irqRequest.low <= ctrlMain_reg[`IPC_B_GIE] & ctrlMain_reg[`IPC_B_GIEL] & (|lowPend);
      wakeUp <= sleeping_reg & anyEnabledPend;
      vectorEnable <= ctrlMain_reg[`IPC_B_GIE];
      if (sleeping_reg && anyEnabledPend)
        sleeping_reg <= 1'b0;
      else if (sleepEnter)
        sleeping_reg <= 1'b1;
    end
  end

  // Context saving on interrupt entry.
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      fastStack <= '0;
      stackPtr_reg <= '0;
      stackTop <= '0;
    end
    else if (interruptTaken)
    begin
      fastStack <= coreContext;
      stackTop <= coreContext.pc;
      if (stackPtr_reg < STACK_DEPTH[$clog2(STACK_DEPTH+1)-1:0])
        stackPtr_reg <= stackPtr_reg + 1'b1;
    end
    else if (fastReturn && stackPtr_reg != '0)
    begin
      stackPtr_reg <= stackPtr_reg - 1'b1;
      stackTop <= (stackPtr_reg > 1) ? stackMem[stackPtr_reg - 2] : '0;
    end
  end
  always_ff @(posedge clock)
  begin
    if (interruptTaken && stackPtr_reg < STACK_DEPTH[$clog2(STACK_DEPTH+1)-1:0])
      stackMem[stackPtr_reg] <= coreContext.pc;
  end

  // AXI4-Lite read path.
  always_comb
  begin
    readHit = 1'b1;
    readData = '0;
    unique case (s_axi_araddr)
      `IPC_OFS_PRIO_A: readData[7:0] = prioA_reg;
      `IPC_OFS_PRIO_B: readData[7:0] = prioB_reg & `IPC_PRIO_B_MASK;
      `IPC_OFS_PRIO_C: readData[7:0] = prioC_reg;
      `IPC_OFS_CTRL_MAIN: readData[7:0] = ctrlMain_reg;
      `IPC_OFS_CTRL_SECOND: readData[7:0] = ctrlSecond_reg;
      `IPC_OFS_CTRL_THIRD: readData[7:0] = ctrlThird_reg;
      `IPC_OFS_CORE: readData[1:0] = {sleeping_reg, t16Mode_reg};
      default: readHit = 1'b0;
    endcase
  end
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `IPC_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= readData;
        s_axi_rresp <= readHit ? `IPC_RESP_OKAY : `IPC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : ipc_controller

// *** logic/ipc_cfg.svh ***
// Constant definitions for the interrupt priority and source controller.
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH
`define IPC_OFS_PRIO_A 8'h00
`define IPC_OFS_PRIO_B 8'h04
`define IPC_OFS_PRIO_C 8'h08
`define IPC_OFS_CTRL_MAIN 8'h0C
`define IPC_OFS_CTRL_SECOND 8'h10
`define IPC_OFS_CTRL_THIRD 8'h14
`define IPC_OFS_FLAGS 8'h18
`define IPC_OFS_CORE 8'h1C
`define IPC_OFS_FAST_STACK 8'h20
`define IPC_OFS_RETURN_PC 8'h24
`define IPC_RST_PRIO 8'hFF
`define IPC_PRIO_B_MASK 8'h4F
`define IPC_RST_CTRL_SECOND 8'hFF
`define IPC_RST_CTRL_THIRD 8'hC0
`define IPC_STACK_DEPTH 31
`define IPC_PC_WIDTH 21
`define IPC_T8_MAX 8'hFF
`define IPC_T16_MAX 16'hFFFF
`define IPC_RESP_OKAY 2'b00
`define IPC_RESP_SLVERR 2'b10
// Main control: 7 global enable, 6 low-priority enable, 5 timer0 enable, 4 pin0 enable,
// 3 port-change enable, 2 timer0 flag, 1 pin0 flag, 0 port-change flag.
`define IPC_B_GIE 7
`define IPC_B_GIEL 6
`define IPC_B_T0IE 5
`define IPC_B_P0IE 4
`define IPC_B_PORT_CHANGE_ENABLE 3
`define IPC_B_T0IF 2
`define IPC_B_P0IF 1
`define IPC_B_PORT_CHANGE_FLAG 0
// Second control: 6..3 edge select pins 0..3, 2 timer0 prio, 1 pin2 prio, 0 port-change prio.
`define IPC_B_EDGE0 6
`define IPC_B_T0IP 2
`define IPC_B_P2IP 1
`define IPC_B_PORT_CHANGE_PRIO 0
// Third control: 7 pin3 prio, 6 pin1 prio, 5..3 enables pins 3..1, 2..0 flags pins 3..1.
`define IPC_B_P3IP 7
`define IPC_B_P1IP 6
`define IPC_B_P1IE 3
`define IPC_B_P1IF 0
// Core control: 1 sleeping, 0 timer0 sixteen-bit mode.
`define IPC_B_SLEEP 1
`define IPC_B_T16 0
`endif

// *** logic/ipc_pkg.sv ***
// Types shared by the interrupt priority and source controller.
package ipc_pkg;
  typedef struct packed {
    logic [20:0] pc;
    logic [7:0] working;
    logic [7:0] status;
    logic [7:0] bank;
  } ipc_context_t;
  typedef struct packed {
    logic high;
    logic low;
  } ipc_request_t;
endpackage : ipc_pkg

// *** logic/ipc_edge_detect.sv ***
// Synchroniser and edge detector for external interrupt pins and port change inputs.
`timescale 1ns/10ps
module ipc_edge_detect #(
  parameter int WIDTH = 4
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinAsync,
  input wire logic [WIDTH-1:0] risingSelect,
  output logic [WIDTH-1:0] validEdge,
  output logic [WIDTH-1:0] anyChange
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] last_reg;

  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      last_reg <= '0;
    end
    else
    begin
      meta_reg <= pinAsync;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      // Rising edge when the select bit is set, falling edge otherwise.
      assign validEdge[i] = risingSelect[i] ? (sync_reg[i] & ~last_reg[i]) : (~sync_reg[i] & last_reg[i]);
      assign anyChange[i] = sync_reg[i] ^ last_reg[i];
    end
  endgenerate
endmodule : ipc_edge_detect

// *** tb/ipc_controller_monitor.sv ***
// Assertion checker watching the interrupt controller ports.
`timescale 1ns/10ps
`include "ipc_cfg.svh"
module ipc_controller_monitor (
  input wire logic clock,
  input wire logic reset,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic interruptTaken,
  input wire logic fastReturn,
  input wire ipc_pkg::ipc_context_t coreContext,
  input wire ipc_pkg::ipc_request_t irqRequest,
  input wire logic wakeUp,
  input wire logic vectorEnable,
  input wire ipc_pkg::ipc_context_t fastStack,
  input wire logic [`IPC_PC_WIDTH-1:0] stackTop
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rvalid_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_bad_read: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > 8'h24)
    |=> s_axi_rresp == `IPC_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
    else $error("bad read not refused");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("ready during write answer");
  a_ctx_saved: assert property (interruptTaken |=> fastStack.working == $past(coreContext.working)
    && fastStack.status == $past(coreContext.status) && fastStack.bank == $past(coreContext.bank))
    else $error("context not saved");
  a_pc_pushed: assert property (interruptTaken && !fastReturn |=> stackTop == $past(coreContext.pc))
    else $error("return address not pushed");
  a_wake_pulse: assert property (wakeUp |=> !wakeUp)
    else $error("wake pulse too long");
  a_low_gated: assert property (irqRequest.low |-> vectorEnable)
    else $error("low request without global enable");
  a_reset_quiet: assert property ($fell(reset) |-> irqRequest == 2'h0 && !wakeUp && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs active after reset");
  c_taken: cover property (interruptTaken);
  c_wake: cover property (wakeUp);
  c_low: cover property (irqRequest.low);
endmodule : ipc_controller_monitor

bind ipc_controller ipc_controller_monitor chk (.clock, .reset, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .interruptTaken, .fastReturn, .coreContext, .irqRequest, .wakeUp, .vectorEnable, .fastStack,
  .stackTop);

// *** tb/ipc_core_model.sv ***
// Behavioural processor core that vectors on requests and returns later.
`timescale 1ns/10ps
module ipc_core_model (
  input wire logic clock,
  input wire logic reset,
  input wire ipc_pkg::ipc_request_t irqRequest,
  input wire logic vectorEnable,
  output logic interruptTaken,
  output logic fastReturn,
  output ipc_pkg::ipc_context_t coreContext,
  output ipc_pkg::ipc_context_t savedCtx,
  output int takenCount
);
  logic [3:0] busy_reg;
  // The context moves every cycle except while it is being handed over.
  always_ff @(posedge clock)
  begin
    interruptTaken <= 1'h0;
    fastReturn <= 1'h0;
    if (reset)
    begin
      busy_reg <= 4'h0;
      takenCount <= 0;
      coreContext <= '0;
    end
    else if (busy_reg == 4'h0 && vectorEnable && (irqRequest.high || irqRequest.low))
    begin
      interruptTaken <= 1'h1;
      savedCtx <= coreContext;
      takenCount <= takenCount + 1;
      busy_reg <= 4'h9;
    end
    else
    begin
      coreContext <= coreContext + 45'h1357_9BDF_2468;
      if (busy_reg != 4'h0)
      begin
        busy_reg <= busy_reg - 4'h1;
        fastReturn <= busy_reg == 4'h1;
      end
    end
  end
endmodule : ipc_core_model

// *** tb/tb.sv ***
// Self-checking bench for the interrupt controller.
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
  begin \
    checks++; \
    if ((got) !== (ex)) \
    begin \
      errors++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
    end \
  end
module tb;
  logic clock, reset, awValid, wValid, bReady, arValid, rReady, sleepEnter;
  logic awReady, wReady, bValid, arReady, rValid, wakeUp, vectorEnable, interruptTaken, fastReturn;
  logic [7:0] awAddr, arAddr, tLow, tHigh;
  logic [31:0] wData, rData;
  logic [1:0] bResp, rResp;
  logic [3:0] pins, portPins;
  logic [23:0] srcReq;
  logic [20:0] stackTop;
  ipc_pkg::ipc_request_t irqRequest;
  ipc_pkg::ipc_context_t coreContext, fastStack, savedCtx;
  int errors, checks, takenCount;
  ipc_controller dut (.clock(clock), .reset(reset), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'h1), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .extIrqPin(pins), .portChangePin(portPins),
    .timer0CountLow(tLow), .timer0CountHigh(tHigh), .peripheralRequest(srcReq[7:0]), .otherRequest(srcReq[23:8]),
    .sleepEnter(sleepEnter), .interruptTaken(interruptTaken), .fastReturn(fastReturn), .coreContext(coreContext),
    .irqRequest(irqRequest), .wakeUp(wakeUp), .vectorEnable(vectorEnable), .fastStack(fastStack),
    .stackTop(stackTop));
  ipc_core_model core (.clock(clock), .reset(reset), .irqRequest(irqRequest), .vectorEnable(vectorEnable),
    .interruptTaken(interruptTaken), .fastReturn(fastReturn), .coreContext(coreContext), .savedCtx(savedCtx),
    .takenCount(takenCount));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    awAddr <= a;
    wData <= {24'h00_0000, d};
    awValid <= 1'h1;
    wValid <= 1'h1;
    bReady <= 1'h1;
    do
    begin
      @(posedge clock);
      if (awReady) awValid <= 1'h0;
      if (wReady) wValid <= 1'h0;
    end
    while (!bValid);
    bReady <= 1'h0;
    `CHK("write resp", 2'h0, bResp)
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    arAddr <= a;
    arValid <= 1'h1;
    rReady <= 1'h1;
    do
    begin
      @(posedge clock);
      if (arReady) arValid <= 1'h0;
    end
    while (!rValid);
    d = rData;
    r = rResp;
    rReady <= 1'h0;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK("register", {24'h00_0000, e}, d)
  endtask : rchk
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    rchk(8'h00, 8'hFF);
    rchk(8'h04, 8'h4F);
    rchk(8'h08, 8'hFF);
    rchk(8'h14, 8'hC0);
    wr(8'h04, 8'hB0);
    rchk(8'h04, 8'h00);
    wr(8'h08, 8'h5A);
    rchk(8'h08, 8'h5A);
    rd(8'h30, d, r);
    `CHK("unmapped resp", 2'h2, r)
    `CHK("unmapped data", 32'h0000_0000, d)
    $display("Test registers done");
  endtask : t_regs
  task automatic t_prio();
    logic p;
    wr(8'h0C, 8'hC0);
    for (int k = 0; k < 2; k++)
    begin
      p = k[0];
      wr(8'h00, {8{p}});
      wr(8'h04, {8{p}});
      wr(8'h08, {8{p}});
      for (int i = 0; i < 24; i++)
      begin
        if (i != 12 && i != 13 && i != 15)
        begin
          srcReq <= 24'h00_0001 << i;
          repeat (3) @(posedge clock);
          `CHK("routed request", {p, ~p}, irqRequest)
          srcReq <= 24'h00_0000;
          repeat (3) @(posedge clock);
          `CHK("idle request", 2'h0, irqRequest)
        end
      end
    end
    $display("Test priority done");
  endtask : t_prio
  task automatic t_pins();
    wr(8'h10, 8'h40);
    wr(8'h14, 8'h00);
    pins <= 4'h2;
    repeat (6) @(posedge clock);
    rchk(8'h14, 8'h00);
    pins <= 4'h0;
    repeat (6) @(posedge clock);
    rchk(8'h14, 8'h01);
    `CHK("masked pin", 2'h0, irqRequest)
    wr(8'h14, 8'h09);
    repeat (3) @(posedge clock);
    `CHK("pin1 low", 2'h1, irqRequest)
    wr(8'h14, 8'h49);
    repeat (3) @(posedge clock);
    `CHK("pin1 high", 2'h2, irqRequest)
    wr(8'h14, 8'h48);
    rchk(8'h14, 8'h48);
    wr(8'h0C, 8'hD0);
    pins <= 4'h1;
    repeat (6) @(posedge clock);
    `CHK("pin0 high", 2'h2, irqRequest)
    rchk(8'h0C, 8'hD2);
    wr(8'h0C, 8'hC0);
    $display("Test pins done");
  endtask : t_pins
  task automatic t_timer();
    wr(8'h0C, 8'hE0);
    tLow <= 8'hFF;
    @(posedge clock);
    tLow <= 8'h00;
    repeat (4) @(posedge clock);
    rchk(8'h0C, 8'hE4);
    `CHK("timer low", 2'h1, irqRequest)
    wr(8'h0C, 8'hE0);
    wr(8'h1C, 8'h01);
    tHigh <= 8'h12;
    tLow <= 8'hFF;
    @(posedge clock);
    tLow <= 8'h00;
    repeat (4) @(posedge clock);
    rchk(8'h0C, 8'hE0);
    tHigh <= 8'hFF;
    tLow <= 8'hFF;
    @(posedge clock);
    tHigh <= 8'h00;
    tLow <= 8'h00;
    repeat (4) @(posedge clock);
    rchk(8'h0C, 8'hE4);
    wr(8'h0C, 8'hC0);
    wr(8'h1C, 8'h00);
    $display("Test timer done");
  endtask : t_timer
  task automatic t_port();
    wr(8'h10, 8'h41);
    wr(8'h0C, 8'hC8);
    portPins <= 4'h4;
    repeat (6) @(posedge clock);
    rchk(8'h0C, 8'hC9);
    `CHK("port high", 2'h2, irqRequest)
    wr(8'h0C, 8'hC0);
    portPins <= 4'h0;
    repeat (6) @(posedge clock);
    rchk(8'h0C, 8'hC1);
    `CHK("port masked", 2'h0, irqRequest)
    wr(8'h0C, 8'hC0);
    $display("Test port done");
  endtask : t_port
  task automatic t_sleep();
    int n;
    logic seen;
    wr(8'h0C, 8'h00);
    wr(8'h10, 8'h60);
    wr(8'h14, 8'h08);
    n = takenCount;
    sleepEnter <= 1'h1;
    @(posedge clock);
    sleepEnter <= 1'h0;
    pins <= 4'h3;
    seen = 1'h0;
    repeat (12)
    begin
      @(posedge clock);
      seen = seen | wakeUp;
    end
    `CHK("wake", 1'h1, seen)
    `CHK("no vector", n, takenCount)
    `CHK("vector off", 1'h0, vectorEnable)
    wr(8'h0C, 8'hC0);
    n = 0;
    while (!interruptTaken && n < 30)
    begin
      @(posedge clock);
      n++;
    end
    `CHK("vectored", 1'h1, interruptTaken)
    repeat (2) @(posedge clock);
    `CHK("fast stack", savedCtx, fastStack)
    `CHK("return pc", savedCtx.pc, stackTop)
    wr(8'h0C, 8'h00);
    $display("Test sleep done");
  endtask : t_sleep
  task automatic test_done();
    $display("Checks %0d, errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : test_done
  initial
  begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  // The tests need about five hundred cycles.
  initial
  begin
    repeat (20000) @(posedge clock);
    errors++;
    test_done();
  end
  initial
  begin
    reset = 1'h1;
    {awValid, wValid, bReady, arValid, rReady, sleepEnter} = '0;
    {awAddr, arAddr, tLow, tHigh, wData, pins, portPins, srcReq} = '0;
    repeat (4) @(posedge clock);
    reset <= 1'h0;
    repeat (2) @(posedge clock);
    t_regs();
    t_prio();
    t_pins();
    t_timer();
    t_port();
    t_sleep();
    test_done();
  end
endmodule : tb
